//--- hw/alu_defines.vh
// Constants of the 8-bit arithmetic, shift and logic unit
`ifndef ALU_DEFINES_VH
`define ALU_DEFINES_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ALU_OFS_CMD 8'h00
`define ALU_OFS_WORK 8'h04
`define ALU_OFS_MEM 8'h08
`define ALU_OFS_IO 8'h0C
`define ALU_OFS_IMM 8'h10
`define ALU_OFS_MULOP 8'h14
`define ALU_OFS_PRODH 8'h18
`define ALU_OFS_FLAGS 8'h1C
`define ALU_OFS_STAT 8'h20
// ----------------------------------------
// Command word fields
// ----------------------------------------
`define ALU_OP_HI 4
`define ALU_OP_LO 0
`define ALU_SEL_HI 6
`define ALU_SEL_LO 5
`define ALU_DST_BIT 7
`define ALU_SEL_IMM 2'h0
`define ALU_SEL_MEM 2'h1
`define ALU_SEL_IO 2'h2
// ----------------------------------------
// Operation codes
// ----------------------------------------
`define ALU_OP_ADD 5'h00
`define ALU_OP_ADDC 5'h01
`define ALU_OP_ADDC1 5'h02
`define ALU_OP_NADD 5'h03
`define ALU_OP_SUB 5'h04
`define ALU_OP_SUBC 5'h05
`define ALU_OP_SUBC1 5'h06
`define ALU_OP_INC 5'h07
`define ALU_OP_DEC 5'h08
`define ALU_OP_CLR 5'h09
`define ALU_OP_MUL 5'h0A
`define ALU_OP_SR 5'h0B
`define ALU_OP_SRC 5'h0C
`define ALU_OP_SL 5'h0D
`define ALU_OP_SLC 5'h0E
`define ALU_OP_SWAP 5'h0F
`define ALU_OP_AND 5'h10
`define ALU_OP_OR 5'h11
`define ALU_OP_XOR 5'h12
`define ALU_OP_NOT 5'h13
`define ALU_OP_NEG 5'h14
`define ALU_OP_CMP 5'h15
// ----------------------------------------
// Flag bits, status bits, reset values and other constants
// ----------------------------------------
`define ALU_FZ 0
`define ALU_FC 1
`define ALU_FAC 2
`define ALU_FOV 3
`define ALU_ST_MEM 0
`define ALU_ST_IO 1
`define ALU_ST_WORK 2
`define ALU_RST_BYTE 8'h00
`define ALU_RST_FLAGS 4'h0
`define ALU_ALL_ONES 8'hFF
`define ALU_ONE 8'h01
`define ALU_TRANS_BIT 1
`endif

//--- hw/alu_core.v
// AHB-Lite slave holding the 8-bit arithmetic, shift and logic datapath
//
// The AHB-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "alu_defines.vh"
module alu_core (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp
);

// ----------------------------------------
// Bus state
// ----------------------------------------
reg wr_pend_q;
reg rd_pend_q;
reg [7:0] addr_q;
wire accept;

// ----------------------------------------
// Datapath registers
// ----------------------------------------
reg [7:0] cmd_q;
reg [7:0] work_q;
reg [7:0] mem_q;
reg [7:0] io_q;
reg [7:0] imm_q;
reg [7:0] mulop_q;
reg [7:0] prodh_q;
reg [3:0] flags_q;
reg [2:0] stat_q;
reg [7:0] cnt_q;

// ----------------------------------------
// Execution signals
// ----------------------------------------
wire exec;
wire [4:0] op;
wire [1:0] sel;
wire dm;
wire [7:0] opnd;
wire [7:0] loc;
wire [7:0] tgt;
wire [15:0] prod;
reg [7:0] p;
reg [7:0] q;
reg cin;
reg arith;
reg subt;
reg [7:0] res;
reg wr_w;
reg wr_loc;
reg wr_m;
reg upd_z;
reg upd_c;
reg new_c;
reg do_mul;
wire [8:0] sum9;
wire [4:0] low5;
wire [7:0] sum8;
wire ovf;
reg [3:0] flags_n;
reg [31:0] rd_d;

// ----------------------------------------
// Bus address phase and read response
// ----------------------------------------
assign accept = hsel & htrans[`ALU_TRANS_BIT] & hready;

always @(posedge hclk or negedge hresetn)
begin
  if (!hresetn)
  begin
    wr_pend_q <= 1'b0;
    rd_pend_q <= 1'b0;
    addr_q <= `ALU_RST_BYTE;
    hreadyout <= 1'b1;
    hresp <= 1'b0;
    hrdata <= 32'h0000_0000;
  end
  else
  begin
    hresp <= 1'b0;
    if (rd_pend_q)
    begin
      rd_pend_q <= 1'b0;
      hreadyout <= 1'b1;
      hrdata <= rd_d;
    end
    else
    begin
      wr_pend_q <= accept & hwrite;
      rd_pend_q <= accept & ~hwrite;
      hreadyout <= ~(accept & ~hwrite);
      if (accept)
        addr_q <= haddr[7:0];
    end
  end
end

// ----------------------------------------
// Command decode
// ----------------------------------------
assign exec = wr_pend_q & (addr_q == `ALU_OFS_CMD);
assign op = hwdata[`ALU_OP_HI:`ALU_OP_LO];
assign sel = hwdata[`ALU_SEL_HI:`ALU_SEL_LO];
assign dm = hwdata[`ALU_DST_BIT];
assign opnd = dm ? loc : (sel == `ALU_SEL_IMM) ? imm_q : (sel == `ALU_SEL_IO) ? io_q : mem_q;
assign loc = (sel == `ALU_SEL_IO) ? io_q : mem_q;
assign tgt = dm ? loc : work_q;
assign prod = {8'h00, work_q} * {8'h00, mulop_q};

// ----------------------------------------
// Adder with nibble and sign carries
// ----------------------------------------
assign sum9 = {1'b0, p} + {1'b0, q} + {8'h00, cin};
assign low5 = {1'b0, p[3:0]} + {1'b0, q[3:0]} + {4'h0, cin};
assign sum8 = sum9[7:0];
assign ovf = (p[7] == q[7]) & (sum8[7] != p[7]);

// ----------------------------------------
// Operation select
// ----------------------------------------
always @*
begin
  p = work_q;
  q = opnd;
  cin = 1'b0;
  arith = 1'b0;
  subt = 1'b0;
  res = sum8;
  wr_w = 1'b0;
  wr_loc = 1'b0;
  wr_m = 1'b0;
  upd_z = 1'b0;
  upd_c = 1'b0;
  new_c = 1'b0;
  do_mul = 1'b0;
  case (op)
    `ALU_OP_ADD:
    begin
      arith = 1'b1;
      wr_w = ~dm;
      wr_loc = dm;
    end
    `ALU_OP_ADDC:
    begin
      cin = flags_q[`ALU_FC];
      arith = 1'b1;
      wr_w = ~dm;
      wr_loc = dm;
    end
    `ALU_OP_ADDC1:
    begin
      p = tgt;
      q = `ALU_RST_BYTE;
      cin = flags_q[`ALU_FC];
      arith = 1'b1;
      wr_w = ~dm;
      wr_loc = dm;
    end
    `ALU_OP_NADD:
    begin
      p = dm ? work_q : mem_q;
      q = dm ? ~mem_q : ~work_q;
      cin = 1'b1;
      arith = 1'b1;
      subt = 1'b1;
      wr_w = ~dm;
      wr_m = dm;
    end
    `ALU_OP_SUB, `ALU_OP_CMP:
    begin
      p = dm ? loc : work_q;
      q = dm ? ~work_q : ~opnd;
      cin = 1'b1;
      arith = 1'b1;
      subt = 1'b1;
      wr_w = ~dm & (op == `ALU_OP_SUB);
      wr_loc = dm & (op == `ALU_OP_SUB);
    end
    `ALU_OP_SUBC:
    begin
      p = dm ? loc : work_q;
      q = dm ? ~work_q : ~opnd;
      cin = ~flags_q[`ALU_FC];
      arith = 1'b1;
      subt = 1'b1;
      wr_w = ~dm;
      wr_loc = dm;
    end
    `ALU_OP_SUBC1:
    begin
      p = tgt;
      q = `ALU_ALL_ONES;
      cin = ~flags_q[`ALU_FC];
      arith = 1'b1;
      subt = 1'b1;
      wr_w = ~dm;
      wr_loc = dm;
    end
    `ALU_OP_INC, `ALU_OP_DEC:
    begin
      p = mem_q;
      q = (op == `ALU_OP_DEC) ? `ALU_ALL_ONES : `ALU_RST_BYTE;
      cin = (op == `ALU_OP_INC);
      arith = 1'b1;
      subt = (op == `ALU_OP_DEC);
      wr_m = 1'b1;
    end
    `ALU_OP_CLR:
    begin
      res = `ALU_RST_BYTE;
      wr_m = 1'b1;
    end
    `ALU_OP_MUL:
    begin
      res = prod[7:0];
      do_mul = 1'b1;
      wr_w = 1'b1;
    end
    `ALU_OP_SR, `ALU_OP_SRC:
    begin
      res = {(op == `ALU_OP_SRC) & flags_q[`ALU_FC], tgt[7:1]};
      new_c = tgt[0];
      upd_c = 1'b1;
      wr_w = ~dm;
      wr_loc = dm;
    end
    `ALU_OP_SL, `ALU_OP_SLC:
    begin
      res = {tgt[6:0], (op == `ALU_OP_SLC) & flags_q[`ALU_FC]};
      new_c = tgt[7];
      upd_c = 1'b1;
      wr_w = ~dm;
      wr_loc = dm;
    end
    `ALU_OP_SWAP:
    begin
      res = {tgt[3:0], tgt[7:4]};
      wr_w = ~dm;
      wr_loc = dm;
    end
    `ALU_OP_AND, `ALU_OP_OR, `ALU_OP_XOR:
    begin
      if (op == `ALU_OP_AND)
        res = work_q & opnd;
      else if (op == `ALU_OP_OR)
        res = work_q | opnd;
      else
        res = work_q ^ opnd;
      upd_z = ~(dm & (sel == `ALU_SEL_IO) & (op == `ALU_OP_XOR));
      wr_w = ~dm;
      wr_loc = dm;
    end
    `ALU_OP_NOT:
    begin
      res = ~tgt;
      upd_z = 1'b1;
      wr_w = ~dm;
      wr_loc = dm;
    end
    `ALU_OP_NEG:
    begin
      res = ~tgt + `ALU_ONE;
      upd_z = 1'b1;
      wr_w = ~dm;
      wr_loc = dm;
    end
    default: res = sum8;
  endcase
end

// ----------------------------------------
// Next flag value
// ----------------------------------------
always @*
begin
  flags_n = flags_q;
  if (arith)
  begin
    flags_n[`ALU_FZ] = (sum8 == `ALU_RST_BYTE);
    flags_n[`ALU_FC] = sum9[8] ^ subt;
    flags_n[`ALU_FAC] = low5[4] ^ subt;
    flags_n[`ALU_FOV] = ovf;
  end
  if (upd_z)
    flags_n[`ALU_FZ] = (res == `ALU_RST_BYTE);
  if (upd_c)
    flags_n[`ALU_FC] = new_c;
end

// ----------------------------------------
// Register writes and execution
// ----------------------------------------
always @(posedge hclk or negedge hresetn)
begin
  if (!hresetn)
  begin
    cmd_q <= `ALU_RST_BYTE;
    work_q <= `ALU_RST_BYTE;
    mem_q <= `ALU_RST_BYTE;
    io_q <= `ALU_RST_BYTE;
    imm_q <= `ALU_RST_BYTE;
    mulop_q <= `ALU_RST_BYTE;
    prodh_q <= `ALU_RST_BYTE;
    flags_q <= `ALU_RST_FLAGS;
    stat_q <= 3'h0;
    cnt_q <= `ALU_RST_BYTE;
  end
  else if (exec)
  begin
    cmd_q <= hwdata[7:0];
    cnt_q <= cnt_q + `ALU_ONE;
    flags_q <= flags_n;
    stat_q[`ALU_ST_WORK] <= wr_w;
    stat_q[`ALU_ST_MEM] <= wr_m | (wr_loc & (sel != `ALU_SEL_IO));
    stat_q[`ALU_ST_IO] <= wr_loc & (sel == `ALU_SEL_IO);
    if (wr_w)
      work_q <= res;
    if (wr_m | (wr_loc & (sel != `ALU_SEL_IO)))
      mem_q <= res;
    if (wr_loc & (sel == `ALU_SEL_IO))
      io_q <= res;
    if (do_mul)
      prodh_q <= prod[15:8];
  end
  else if (wr_pend_q)
  begin
    case (addr_q)
      `ALU_OFS_WORK: work_q <= hwdata[7:0];
      `ALU_OFS_MEM: mem_q <= hwdata[7:0];
      `ALU_OFS_IO: io_q <= hwdata[7:0];
      `ALU_OFS_IMM: imm_q <= hwdata[7:0];
      `ALU_OFS_MULOP: mulop_q <= hwdata[7:0];
      `ALU_OFS_PRODH: prodh_q <= hwdata[7:0];
      `ALU_OFS_FLAGS: flags_q <= hwdata[3:0];
      default: cnt_q <= cnt_q;
    endcase
  end
end

// ----------------------------------------
// Read data select
// ----------------------------------------
always @*
begin
  rd_d = 32'h0000_0000;
  case (addr_q)
    `ALU_OFS_CMD: rd_d[7:0] = cmd_q;
    `ALU_OFS_WORK: rd_d[7:0] = work_q;
    `ALU_OFS_MEM: rd_d[7:0] = mem_q;
    `ALU_OFS_IO: rd_d[7:0] = io_q;
    `ALU_OFS_IMM: rd_d[7:0] = imm_q;
    `ALU_OFS_MULOP: rd_d[7:0] = mulop_q;
    `ALU_OFS_PRODH: rd_d[7:0] = prodh_q;
    `ALU_OFS_FLAGS: rd_d[3:0] = flags_q;
    `ALU_OFS_STAT: rd_d[15:0] = {cnt_q, 5'h00, stat_q};
    default: rd_d = 32'h0000_0000;
  endcase
end

endmodule // alu_core

//--- dv/alu_host.sv
// AHB-Lite host model driving the datapath registers
`timescale 1ns/1ps
module alu_host (
  input wire hclk,
  input wire hready,
  input wire [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : ~hwdata;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
endmodule // alu_host

//--- dv/alu_core_asserts.sv
// Bus timing and data width checks on the datapath slave
`timescale 1ns/1ps
module alu_chk (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic rd_q;
  logic [7:0] ofs_q;
  wire take = hsel & htrans[1] & hready;
  wire done = rd_q & hreadyout;
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_q <= 1'b0;
      ofs_q <= 8'h00;
    end
    else if (take)
    begin
      rd_q <= !hwrite;
      ofs_q <= haddr[7:0];
    end
    else if (done)
      rd_q <= 1'b0;
  end
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("bad resp");
  property p_rd_wait;
    take && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("bad read wait");
  property p_one;
    !hreadyout |=> hreadyout;
  endproperty
  a_one: assert property (p_one) else $error("long wait");
  property p_wr;
    take && hwrite |=> hreadyout;
  endproperty
  a_wr: assert property (p_wr) else $error("write wait");
  property p_upper;
    done && ofs_q != 8'h20 |-> hrdata[31:8] == 24'h00_0000;
  endproperty
  a_upper: assert property (p_upper) else $error("upper bits set");
  property p_flag4;
    done && ofs_q == 8'h1C |-> hrdata[31:4] == 28'h000_0000;
  endproperty
  a_flag4: assert property (p_flag4) else $error("flag width");
  property p_unmap;
    done && ofs_q > 8'h20 |-> hrdata == 32'h0000_0000;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped data");
  property p_hold;
    !rd_q |=> $stable(hrdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  c_rd: cover property (done && ofs_q == 8'h1C);
  c_wr: cover property (take && hwrite);
  c_un: cover property (done && ofs_q > 8'h20);
endmodule // alu_chk
bind alu_core alu_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

//--- dv/alu_core_tb.sv
// Self-checking bench for the datapath against a behavioural model
`timescale 1ns/1ps
module alu_core_tb;
  logic hclk;
  logic hresetn;
  wire hsel;
  wire [31:0] haddr;
  wire [1:0] htrans;
  wire hwrite;
  wire [2:0] hsize;
  wire [31:0] hwdata;
  wire [31:0] hrdata;
  wire hreadyout;
  wire hresp;
  logic [31:0] seed = 32'h0000_0011;
  logic [31:0] q;
  int mismatches = 0;
  int n_tests = 0;
  int cyc = 0;
  int w, m, io, im, mo, ph, f, n_cmd;
  alu_core uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  alu_host h (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  function automatic int rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed & 255;
  endfunction
  // Add or subtract; flags in bits 11:8
  function automatic int ar(int p, int b, int ci, int sb);
    int k, r, c, hc, v;
    k = sb ? ~b & 255 : b;
    ci = sb ? 1 - ci : ci;
    r = p + k + ci;
    c = (r >> 8 & 1) ^ sb;
    hc = ((p & 15) + (k & 15) + ci >> 4 & 1) ^ sb;
    v = p[7] == k[7] && r[7] != p[7];
    return (r & 255) | ((r & 255) == 0) << 8 | c << 9 | hc << 10 | v << 11;
  endfunction
  task automatic wr(input logic [7:0] a, input int d);
    h.xfer(1'b1, a, d[31:0], q);
  endtask
  task automatic cmp(input logic [7:0] a, input int e);
    h.xfer(1'b0, a, 32'h0000_0000, q);
    n_tests++;
    if (q !== e[31:0])
    begin
      mismatches++;
      $display("BAD reg %h exp %h got %h", a, e, q);
    end
  endtask
  task automatic one(input int op);
    int sel, dst, o, t, tg, c, nc, x, r, zf;
    sel = rnd() & 3;
    dst = rnd() & 1;
    w = rnd();
    m = rnd();
    io = rnd();
    im = rnd();
    mo = rnd();
    f = rnd() & 15;
    wr(8'h04, w);
    wr(8'h08, m);
    wr(8'h0C, io);
    wr(8'h10, im);
    wr(8'h14, mo);
    wr(8'h1C, f);
    wr(8'h00, op | sel << 5 | dst << 7);
    n_cmd = (n_cmd + 1) % 256;
    tg = dst ? (sel == 2 ? 2 : 1) : 0;
    t = tg == 0 ? w : tg == 1 ? m : io;
    o = dst ? t : sel == 0 ? im : sel == 2 ? io : m;
    c = f >> 1 & 1;
    nc = c;
    x = -1;
    zf = 0;
    r = t;
    case (op)
      0, 1: x = ar(w, o, op == 1 ? c : 0, 0);
      2: x = ar(t, 0, c, 0);
      3:
      begin
        x = dst ? ar(w, m, 0, 1) : ar(m, w, 0, 1);
        tg = dst;
      end
      4, 5, 21: x = dst ? ar(t, w, op == 5 ? c : 0, 1) : ar(w, o, op == 5 ? c : 0, 1);
      6: x = ar(t, 0, c, 1);
      7, 8:
      begin
        x = ar(m, 1, 0, op - 7);
        tg = 1;
      end
      9: tg = 1;
      10:
      begin
        ph = w * mo >> 8;
        tg = 0;
      end
      11, 12: nc = t & 1;
      13, 14: nc = t >> 7;
      16, 17, 18: zf = op != 18 || tg != 2;
      19, 20: zf = 1;
    endcase
    case (op)
      9: r = 0;
      10: r = w * mo & 255;
      11, 12: r = t >> 1 | (op == 12 ? c << 7 : 0);
      13, 14: r = (t << 1) & 255 | (op == 14 ? c : 0);
      15: r = (t << 4 | t >> 4) & 255;
      16: r = w & o;
      17: r = w | o;
      18: r = w ^ o;
      19: r = ~t & 255;
      20: r = -t & 255;
    endcase
    if (x >= 0)
    begin
      r = x & 255;
      f = x >> 8;
    end
    else
      f = (f & 13) | nc << 1;
    if (zf)
      f = (f & 14) | (r == 0);
    if (op != 21)
      case (tg)
        0: w = r;
        1: m = r;
        default: io = r;
      endcase
    cmp(8'h04, w);
    cmp(8'h08, m);
    cmp(8'h0C, io);
    cmp(8'h18, ph);
    cmp(8'h1C, f);
    cmp(8'h00, op | sel << 5 | dst << 7);
    cmp(8'h20, n_cmd << 8 | (op > 20 ? 0 : tg == 0 ? 4 : tg == 1 ? 1 : 2));
  endtask
  task test_done;
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      mismatches++;
      test_done;
    end
  end
  initial
  begin
    ph = 0;
    hresetn = 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    cmp(8'h1C, 0);
    cmp(8'h04, 0);
    cmp(8'h20, 0);
    wr(8'h24, 255);
    cmp(8'h24, 0);
    for (int i = 0; i < 256; i++)
      one(i % 32);
    test_done;
  end
endmodule // alu_core_tb
